// *** include/ee_pkg.sv ***
// Constants, state codes and timing shared by the serial memory slave.
// Assumes a 20 MHz system clock and a free-running link sampling clock.
package ee_pkg;

	// Array and page geometry
	localparam int ADDR_W = 8;
	localparam int DATA_W = 8;
	localparam int PAGE_W = 4;
	localparam int PAGE_BYTES = 16;

	// Bit counter positions within one byte frame
	localparam logic [3:0] BIT_LAST = 4'h7;
	localparam logic [3:0] BIT_ACK = 4'h8;

	// Commit walk ends one step after the last page slot
	localparam logic [4:0] COMMIT_END = 5'h10;

	// Programming time, as a longest time rounded down to whole cycles
	localparam int WR_TIME_MS = 5;
	localparam int REF_CLK_KHZ = 20_000;
	localparam int WR_CYCLES = WR_TIME_MS * REF_CLK_KHZ;

	// Reset values
	localparam logic [ADDR_W-1:0] PTR_RST = 8'h00;
	localparam logic [PAGE_BYTES-1:0] VALID_RST = 16'h0000;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_DEVADDR = 3'b001,
		ST_WORDADDR = 3'b010,
		ST_WDATA = 3'b011,
		ST_RDATA = 3'b100,
		ST_PROG = 3'b101,
		ST_COMMIT = 3'b110
	} ee_state_e;

endpackage : ee_pkg

// *** include/ee_mem_if.sv ***
// Carrier between the slave controller and its memories.
// Assumes the memory samples these on the controller's clock.
interface ee_mem_if #(parameter int AW = 8);
	logic we;
	logic [AW-1:0] waddr;
	logic [AW-1:0] raddr;
	logic [7:0] wdata;
	logic [7:0] rdata;
	modport ctrl (output we, output waddr, output wdata, output raddr, input rdata);
	modport mem (input we, input waddr, input wdata, input raddr, output rdata);
endinterface : ee_mem_if

// *** rtl/ee_sync.sv ***
// Two-flop synchroniser for a bundle of independent levels.
// Assumes each bit is a level; the bits are not coherent as a word.
module ee_sync #(
	parameter int W = 1
) (
	// Clock
	input wire logic clk,
	// Levels in and out
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta_reg;

	// First stage feeds only the second
	always_ff @(posedge clk) begin
		meta_reg <= d;
		q <= meta_reg;
	end
endmodule : ee_sync

// *** rtl/ee_mem.sv ***
// Simple dual-port byte memory with registered read data.
// Assumes one clock; contents are not reset.
module ee_mem #(
	parameter int AW = 8
) (
	// Clock and enable
	input wire logic clk,
	input wire logic ce,
	// Access port
	ee_mem_if.mem port
);
	logic [7:0] mem_arr [2**AW];

	always_ff @(posedge clk) begin
		if (ce) begin
			if (port.we) begin
				mem_arr[port.waddr] <= port.wdata;
			end
			port.rdata <= mem_arr[port.raddr];
		end
	end
endmodule : ee_mem

// *** rtl/ee_top.sv ***
// Two-wire serial slave in front of a 256 x 8 non-volatile array.
// Assumes a fast free-running link_clk that oversamples the bus pins,
// and a 20 MHz ref_clk that times the programming cycle.
module ee_top
	import ee_pkg::*;
#(
	parameter int unsigned WR_CYCLES_P = WR_CYCLES,
	// Type code value is arbitrary
	parameter logic [3:0] TYPE_CODE = 4'h6
) (
	// System clock and control
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic ce,
	// Bus pins, sampled on the link clock
	input wire logic link_clk,
	input wire logic scl_i,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe,
	// Straps
	input wire logic addr_strap_bit0,
	input wire logic addr_strap_bit1,
	input wire logic addr_strap_bit2,
	input wire logic wp_i,
	// Status
	output logic standby,
	output logic prog_busy
);
	// Link domain inputs
	logic [8:0] lsync_in;
	logic [8:0] lsync_out;
	logic done_tgl_reg;
	logic done_s;
	logic lrst_n;
	logic lce;
	logic scl_s;
	logic sda_s;
	logic [2:0] strap_s;
	logic wp_s;

	assign lsync_in = {done_tgl_reg, rst_n, ce, scl_i, sda_i, addr_strap_bit2, addr_strap_bit1,
		addr_strap_bit0, wp_i};

	ee_sync #(.W(9)) u_lsync (
		.clk(link_clk),
		.d(lsync_in),
		.q(lsync_out)
	);

	assign {done_s, lrst_n, lce, scl_s, sda_s, strap_s, wp_s} = lsync_out;

	// Link state
	ee_state_e state_reg, state_next;
	logic scl_d_reg;
	logic sda_d_reg;
	logic sda_d2_reg;
	logic [3:0] bit_reg, bit_next;
	logic [7:0] rx_reg, rx_next;
	logic [7:0] tx_reg, tx_next;
	logic ack_reg, ack_next;
	logic rw_reg, rw_next;
	logic oe_reg, oe_next;
	logic [ADDR_W-1:0] ptr_reg, ptr_next;
	logic [PAGE_W-1:0] base_reg, base_next;
	logic [PAGE_BYTES-1:0] valid_reg, valid_next;
	logic [4:0] cidx_reg, cidx_next;
	logic req_tgl_reg, req_tgl_next;
	logic done_seen_reg, done_seen_next;
	logic standby_reg;
	logic buf_we;

	// Bus event decode
	wire scl_rise = scl_s & ~scl_d_reg;
	wire scl_fall = ~scl_s & scl_d_reg;
	wire scl_high = scl_s & scl_d_reg;
	// Data is seen one sample late so a zero-hold change at the falling clock is never a condition
	wire start_det = scl_high & sda_d2_reg & ~sda_d_reg;
	wire stop_det = scl_high & ~sda_d2_reg & sda_d_reg;
	wire [7:0] byte_in = {rx_reg[6:0], sda_d_reg};
	wire addr_match = (byte_in[7:4] == TYPE_CODE) && (byte_in[3:1] == strap_s);
	wire busy_st = (state_reg == ST_PROG) || (state_reg == ST_COMMIT);
	wire [PAGE_W-1:0] cidx_m1 = 4'(cidx_reg - 5'h01);
	wire commit_we = (state_reg == ST_COMMIT) && (cidx_reg != 5'h00) && valid_reg[cidx_m1];

	// Memories: array read on the pointer and written by the commit walk, page buffer written on the pointer's low nibble
	ee_mem_if #(.AW(ADDR_W)) arr_if ();
	ee_mem_if #(.AW(PAGE_W)) buf_if ();

	assign arr_if.raddr = ptr_reg;
	assign arr_if.we = commit_we;
	assign arr_if.waddr = {base_reg, cidx_m1};
	assign arr_if.wdata = buf_if.rdata;
	assign buf_if.raddr = cidx_reg[PAGE_W-1:0];
	assign buf_if.we = buf_we;
	assign buf_if.waddr = ptr_reg[PAGE_W-1:0];
	assign buf_if.wdata = byte_in;

	ee_mem #(.AW(ADDR_W)) u_array (
		.clk(link_clk),
		.ce(lce),
		.port(arr_if.mem)
	);

	ee_mem #(.AW(PAGE_W)) u_page (
		.clk(link_clk),
		.ce(lce),
		.port(buf_if.mem)
	);

	always_comb begin
		state_next = state_reg;
		bit_next = bit_reg;
		rx_next = rx_reg;
		tx_next = tx_reg;
		ack_next = ack_reg;
		rw_next = rw_reg;
		oe_next = oe_reg;
		ptr_next = ptr_reg;
		base_next = base_reg;
		valid_next = valid_reg;
		cidx_next = cidx_reg;
		req_tgl_next = req_tgl_reg;
		done_seen_next = done_seen_reg;
		buf_we = 1'b0;
		if (start_det && !busy_st) begin
			// Any start outside programming and commit, mid-byte or not, restarts framing
			state_next = ST_DEVADDR;
			bit_next = 4'h0;
			oe_next = 1'b0;
			valid_next = VALID_RST;
		end else if (stop_det && !busy_st) begin
			bit_next = 4'h0;
			oe_next = 1'b0;
			if (state_reg == ST_WDATA && valid_reg != VALID_RST && !wp_s) begin
				state_next = ST_PROG;
				req_tgl_next = ~req_tgl_reg;
			end else begin
				state_next = ST_IDLE;
			end
		end else begin
			case (state_reg)
				ST_IDLE: begin
				end
				ST_PROG: begin
					if (done_s != done_seen_reg) begin
						done_seen_next = done_s;
						state_next = ST_COMMIT;
						cidx_next = 5'h00;
					end
				end
				ST_COMMIT: begin
					cidx_next = cidx_reg + 5'h01;
					if (cidx_reg == COMMIT_END) begin
						state_next = ST_IDLE;
						valid_next = VALID_RST;
					end
				end
				default: begin
					if (scl_rise) begin
						if (bit_reg != BIT_ACK) begin
							rx_next = byte_in;
							bit_next = bit_reg + 4'h1;
							if (bit_reg == BIT_LAST) begin
								case (state_reg)
									ST_DEVADDR: begin
										ack_next = addr_match;
										rw_next = byte_in[0];
									end
									ST_WORDADDR: begin
										ack_next = 1'b1;
										ptr_next = byte_in;
									end
									ST_WDATA: begin
										ack_next = 1'b1;
										buf_we = 1'b1;
										valid_next[ptr_reg[PAGE_W-1:0]] = 1'b1;
										base_next = ptr_reg[ADDR_W-1:PAGE_W];
										ptr_next = {ptr_reg[ADDR_W-1:PAGE_W], ptr_reg[PAGE_W-1:0] + 4'h1};
									end
									default: begin
									end
								endcase
							end
						end else begin
							bit_next = 4'h0;
							case (state_reg)
								ST_DEVADDR: begin
									if (!ack_reg) begin
										state_next = ST_IDLE;
									end else if (rw_reg) begin
										state_next = ST_RDATA;
									end else begin
										state_next = ST_WORDADDR;
									end
								end
								ST_WORDADDR: state_next = ST_WDATA;
								ST_RDATA: begin
									ptr_next = ptr_reg + 8'h01;
									if (sda_d_reg) begin
										state_next = ST_IDLE;
									end
								end
								default: begin
								end
							endcase
						end
					end else if (scl_fall) begin
						if (state_reg == ST_RDATA) begin
							if (bit_reg == 4'h0) begin
								tx_next = {arr_if.rdata[6:0], 1'b0};
								oe_next = ~arr_if.rdata[7];
							end else if (bit_reg != BIT_ACK) begin
								tx_next = {tx_reg[6:0], 1'b0};
								oe_next = ~tx_reg[7];
							end else begin
								oe_next = 1'b0;
							end
						end else begin
							oe_next = (bit_reg == BIT_ACK) && ack_reg;
						end
					end
				end
			endcase
		end
	end

	always_ff @(posedge link_clk) begin
		if (!lrst_n) begin
			state_reg <= ST_IDLE;
			scl_d_reg <= 1'b1;
			sda_d_reg <= 1'b1;
			sda_d2_reg <= 1'b1;
			bit_reg <= 4'h0;
			rx_reg <= 8'h00;
			tx_reg <= 8'h00;
			ack_reg <= 1'b0;
			rw_reg <= 1'b0;
			oe_reg <= 1'b0;
			ptr_reg <= PTR_RST;
			base_reg <= 4'h0;
			valid_reg <= VALID_RST;
			cidx_reg <= 5'h00;
			req_tgl_reg <= 1'b0;
			done_seen_reg <= 1'b0;
			standby_reg <= 1'b1;
		end else if (lce) begin
			state_reg <= state_next;
			scl_d_reg <= scl_s;
			sda_d_reg <= sda_s;
			sda_d2_reg <= sda_d_reg;
			bit_reg <= bit_next;
			rx_reg <= rx_next;
			tx_reg <= tx_next;
			ack_reg <= ack_next;
			rw_reg <= rw_next;
			oe_reg <= oe_next;
			ptr_reg <= ptr_next;
			base_reg <= base_next;
			valid_reg <= valid_next;
			cidx_reg <= cidx_next;
			req_tgl_reg <= req_tgl_next;
			done_seen_reg <= done_seen_next;
			standby_reg <= (state_next == ST_IDLE);
		end
	end

	// Open drain: only ever pulls low
	assign sda_o = 1'b0;
	assign sda_oe = oe_reg;
	assign standby = standby_reg;

	// Programming timer on the system clock
	logic req_s;
	logic req_seen_reg;
	logic busy_reg;
	logic [31:0] wr_cnt_reg;

	ee_sync #(.W(1)) u_rsync (
		.clk(ref_clk),
		.d(req_tgl_reg),
		.q(req_s)
	);

	wire wr_done = busy_reg && (wr_cnt_reg == WR_CYCLES_P - 1);

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			req_seen_reg <= 1'b0;
			busy_reg <= 1'b0;
			wr_cnt_reg <= 32'h0000_0000;
			done_tgl_reg <= 1'b0;
		end else if (ce) begin
			if (!busy_reg && req_s != req_seen_reg) begin
				req_seen_reg <= req_s;
				busy_reg <= 1'b1;
				wr_cnt_reg <= 32'h0000_0000;
			end else if (wr_done) begin
				busy_reg <= 1'b0;
				done_tgl_reg <= ~done_tgl_reg;
			end else if (busy_reg) begin
				wr_cnt_reg <= wr_cnt_reg + 32'h0000_0001;
			end
		end
	end

	assign prog_busy = busy_reg;

	// Checks on the link logic and the programming timer
	a_type_mismatch: assert property (@(posedge link_clk) disable iff (!lrst_n)
		lce && state_reg == ST_DEVADDR && scl_rise && bit_reg == BIT_LAST && !start_det && !stop_det
		&& byte_in[7:4] != TYPE_CODE |=> !ack_reg)
		else $error("address with wrong type code was accepted");

	a_strap_mismatch: assert property (@(posedge link_clk) disable iff (!lrst_n)
		lce && state_reg == ST_DEVADDR && scl_rise && bit_reg == BIT_LAST && !start_det && !stop_det
		&& byte_in[3:1] != strap_s |=> !ack_reg)
		else $error("address with wrong strap bits was accepted");

	a_dir_read: assert property (@(posedge link_clk) disable iff (!lrst_n)
		lce && state_reg == ST_DEVADDR && scl_rise && bit_reg == BIT_ACK && ack_reg && rw_reg
		&& !start_det && !stop_det |=> state_reg == ST_RDATA)
		else $error("read direction did not enter read state");

	a_ack_ninth: assert property (@(posedge link_clk) disable iff (!lrst_n)
		lce && state_reg == ST_DEVADDR && scl_fall && bit_reg == BIT_ACK && ack_reg
		&& !start_det && !stop_det |=> sda_oe)
		else $error("matching address not acknowledged");

	a_busy_silent: assert property (@(posedge link_clk) disable iff (!lrst_n)
		busy_st |-> !sda_oe)
		else $error("data line driven while programming");

	a_page_wrap: assert property (@(posedge link_clk) disable iff (!lrst_n)
		lce && state_reg == ST_WDATA && scl_rise && bit_reg == BIT_LAST && !start_det && !stop_det
		|=> ptr_reg[7:4] == $past(ptr_reg[7:4]) && ptr_reg[3:0] == $past(ptr_reg[3:0]) + 4'h1)
		else $error("page write pointer did not wrap in page");

	a_read_incr: assert property (@(posedge link_clk) disable iff (!lrst_n)
		lce && state_reg == ST_RDATA && scl_rise && bit_reg == BIT_ACK && !start_det && !stop_det
		|=> ptr_reg == $past(ptr_reg) + 8'h01)
		else $error("read pointer did not advance");

	a_start_resync: assert property (@(posedge link_clk) disable iff (!lrst_n)
		lce && start_det && !busy_st |=> state_reg == ST_DEVADDR && bit_reg == 4'h0 && !sda_oe)
		else $error("start condition did not restart framing");

	a_wp_skip: assert property (@(posedge link_clk) disable iff (!lrst_n)
		lce && stop_det && state_reg == ST_WDATA && wp_s |=> state_reg == ST_IDLE && !busy_st)
		else $error("protected write started programming");

	a_prog_bound: assert property (@(posedge ref_clk) disable iff (!rst_n)
		busy_reg |-> wr_cnt_reg < WR_CYCLES_P)
		else $error("programming cycle ran too long");

endmodule : ee_top

// *** verification/ee_bus_master.sv ***
// Two-wire bus master model: drives the bus clock and an open-drain data pull.
// Assumes sda is the resolved wire with a pull-up; all changes follow link_clk.
module ee_bus_master (
	// Link clock
	input wire logic link_clk,
	// Bus
	input wire logic sda,
	output logic scl,
	output logic sda_pull
);
	timeunit 1ns;
	timeprecision 100ps;
	localparam int H = 8;
	initial begin
		scl = 1'b1;
		sda_pull = 1'b0;
	end
	task automatic gap(input int n);
		repeat (n) @(posedge link_clk);
	endtask : gap
	// Data released before the clock rises, so a repeated start is safe
	task automatic start_cond;
		sda_pull <= 1'b0;
		gap(H);
		scl <= 1'b1;
		gap(H);
		sda_pull <= 1'b1;
		gap(H);
		scl <= 1'b0;
		gap(H);
	endtask : start_cond
	task automatic stop_cond;
		sda_pull <= 1'b1;
		gap(H);
		scl <= 1'b1;
		gap(H);
		sda_pull <= 1'b0;
		gap(2 * H);
	endtask : stop_cond
	// Data moves two cycles after the fall, never while the clock is high
	task automatic bit_io(input logic b, output logic r);
		sda_pull <= ~b;
		gap(H);
		scl <= 1'b1;
		gap(H / 2);
		r = sda;
		gap(H / 2);
		scl <= 1'b0;
		gap(2);
	endtask : bit_io
	task automatic send_byte(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_io(d[i], r);
		end
		bit_io(1'b1, r);
		ack = ~r;
	endtask : send_byte
	task automatic get_byte(input logic ack, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_io(1'b1, r);
			d[i] = r;
		end
		bit_io(~ack, r);
	endtask : get_byte
	// Limitation: the slave may drive the bit after the high one, which would mask the start
	task automatic recover;
		logic r;
		for (int i = 0; i < 9; i++) begin
			bit_io(1'b1, r);
			if (r === 1'b1) begin
				break;
			end
		end
		start_cond();
	endtask : recover
endmodule : ee_bus_master

// *** verification/ee_top_tb.sv ***
// Self-checking bench for the two-wire serial memory slave.
// Assumes the master model owns the bus clock; the data wire has a pull-up.
module ee_top_tb
	import ee_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	localparam int WR_P = 50;
	// Type code value is arbitrary
	localparam logic [3:0] TC = 4'h6;
	localparam logic [2:0] STRAP = 3'h5;
	logic ref_clk = 1'b0;
	logic link_clk = 1'b0;
	logic rst_n = 1'b0;
	logic ce = 1'b1;
	logic wp_i = 1'b0;
	logic [2:0] strap = STRAP;
	logic scl, pull, sda_o, sda_oe, standby, prog_busy, sda;
	int err_total = 0;
	int tests_run = 0;
	assign sda = (sda_oe === 1'b1 ? sda_o : 1'b1) & ~pull;
	always #25 ref_clk = ~ref_clk;
	// Offset start so link edges never meet system clock edges
	initial begin
		#1.3;
		forever #3 link_clk = ~link_clk;
	end
	ee_top #(.WR_CYCLES_P(WR_P), .TYPE_CODE(TC)) uut (
		.ref_clk(ref_clk), .rst_n(rst_n), .ce(ce), .link_clk(link_clk), .scl_i(scl),
		.sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe), .addr_strap_bit0(strap[0]),
		.addr_strap_bit1(strap[1]), .addr_strap_bit2(strap[2]), .wp_i(wp_i),
		.standby(standby), .prog_busy(prog_busy));
	ee_bus_master m (.link_clk(link_clk), .sda(sda), .scl(scl), .sda_pull(pull));
	task automatic check_bit(input logic got, input logic exp);
		tests_run++;
		if (got !== exp) begin
			err_total++;
			$display("unexpected at %0t: bit %b, wanted %b", $time, got, exp);
		end
	endtask : check_bit
	task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
		tests_run++;
		if (got !== exp) begin
			err_total++;
			$display("unexpected at %0t: byte %h, wanted %h", $time, got, exp);
		end
	endtask : check_byte
	task automatic finish_test;
		$display("checks %0d, mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : finish_test
	task automatic open_tx(input logic rd);
		logic a;
		m.start_cond();
		m.send_byte({TC, STRAP, rd}, a);
		check_bit(a, 1'b1);
	endtask : open_tx
	task automatic set_ptr(input logic [7:0] wa);
		logic a;
		open_tx(1'b0);
		m.send_byte(wa, a);
		check_bit(a, 1'b1);
	endtask : set_ptr
	task automatic write_tx(input logic [7:0] wa, input logic [7:0] d[$]);
		logic a;
		set_ptr(wa);
		foreach (d[i]) begin
			m.send_byte(d[i], a);
			check_bit(a, 1'b1);
		end
		m.stop_cond();
	endtask : write_tx
	// Acks every byte but the last, then stops
	task automatic read_tx(input logic [7:0] e[$]);
		logic [7:0] g;
		open_tx(1'b1);
		foreach (e[i]) begin
			m.get_byte(i < e.size() - 1, g);
			check_byte(g, e[i]);
		end
		m.stop_cond();
	endtask : read_tx
	// Polls are refused while busy, answered once the write has landed
	task automatic wait_prog;
		int n;
		logic a;
		n = 0;
		// Busy is a ref_clk register, so it is looked at on the falling edge
		while (prog_busy !== 1'b1 && n < 10) begin
			@(negedge ref_clk);
			n++;
		end
		check_bit(prog_busy, 1'b1);
		check_bit(standby, 1'b0);
		n = 0;
		fork
			while (prog_busy === 1'b1 && n < 2 * WR_P) begin
				@(negedge ref_clk);
				n++;
			end
			begin
				m.start_cond();
				m.send_byte({TC, STRAP, 1'b0}, a);
				check_bit(a, 1'b0);
				m.stop_cond();
			end
		join
		check_bit(n >= WR_P - 2 && n <= WR_P, 1'b1);
		for (int i = 0; i < 20 && a !== 1'b1; i++) begin
			m.start_cond();
			m.send_byte({TC, STRAP, 1'b0}, a);
			m.stop_cond();
		end
		check_bit(a, 1'b1);
		repeat (4) @(negedge ref_clk);
		check_bit(standby, 1'b1);
	endtask : wait_prog
	task automatic t_addr;
		logic a;
		for (int s = 0; s < 9; s++) begin
			m.start_cond();
			m.send_byte(s < 8 ? {TC, s[2:0], 1'b0} : {~TC, STRAP, 1'b0}, a);
			check_bit(a, s == STRAP);
			m.stop_cond();
		end
		$display("addressing done");
	endtask : t_addr
	task automatic t_page;
		logic [7:0] d[$];
		logic [7:0] e[$];
		for (int i = 0; i < PAGE_BYTES; i++) begin
			e.push_back(8'h00);
		end
		for (int i = 0; i < PAGE_BYTES + 2; i++) begin
			d.push_back(8'(8'h80 + i));
			e[(14 + i) % PAGE_BYTES] = 8'(8'h80 + i);
		end
		write_tx(8'h3E, d);
		wait_prog();
		read_tx('{e[0]});
		set_ptr(8'h30);
		read_tx(e);
		$display("page write done");
	endtask : t_page
	task automatic t_rest;
		logic r;
		write_tx(8'h00, '{8'h3C});
		wait_prog();
		write_tx(8'hFF, '{8'hC3});
		wait_prog();
		set_ptr(8'hFF);
		read_tx('{8'hC3});
		read_tx('{8'h3C});
		set_ptr(8'hFF);
		read_tx('{8'hC3, 8'h3C});
		wp_i <= 1'b1;
		write_tx(8'h00, '{8'hEE});
		repeat (10) @(negedge ref_clk);
		check_bit(prog_busy, 1'b0);
		check_bit(standby, 1'b1);
		wp_i <= 1'b0;
		set_ptr(8'h00);
		read_tx('{8'h3C});
		// Known byte 0x3C: cut after three bits, so the fourth and fifth are high
		set_ptr(8'h00);
		open_tx(1'b1);
		repeat (3) m.bit_io(1'b1, r);
		m.recover();
		m.stop_cond();
		set_ptr(8'hFF);
		read_tx('{8'hC3});
		$display("byte, wrap, protect and recovery done");
	endtask : t_rest
	// A frozen slave must let a whole matching address pass unanswered
	task automatic t_freeze;
		logic a;
		ce <= 1'b0;
		repeat (4) @(posedge ref_clk);
		m.start_cond();
		m.send_byte({TC, STRAP, 1'b0}, a);
		check_bit(a, 1'b0);
		m.stop_cond();
		check_bit(standby, 1'b1);
		check_bit(prog_busy, 1'b0);
		ce <= 1'b1;
		repeat (4) @(posedge ref_clk);
		$display("clock enable done");
	endtask : t_freeze
	// Full run is near 2100 system cycles; the limit leaves ample margin
	initial begin
		repeat (8000) @(posedge ref_clk);
		err_total++;
		$display("unexpected at %0t: watchdog expired", $time);
		finish_test();
	end
	initial begin
		repeat (10) @(posedge ref_clk);
		rst_n <= 1'b1;
		repeat (10) @(posedge ref_clk);
		check_bit(sda_oe, 1'b0);
		check_bit(standby, 1'b1);
		check_bit(prog_busy, 1'b0);
		$display("reset done");
		t_freeze();
		t_addr();
		t_rest();
		t_page();
		finish_test();
	end
endmodule : ee_top_tb
